/* verilog/ssm_pkg.sv */
// Purpose: Shared constants, types and helpers for the multiply/negate unit
// Assumes: 36-bit accumulators, 16-bit operand registers, 32-bit APB data
// Notes:   Register offsets are byte addresses on an 8-bit APB address
`default_nettype none
package ssm_pkg;
  localparam int ACC_W = 36;
  localparam int WRD_W = 16;
  localparam int NUM_ACC = 4;
  // APB register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_OMR      = 8'h04;
  localparam logic [7:0] OFF_CCR      = 8'h08;
  localparam logic [7:0] OFF_X0       = 8'h0c;
  localparam logic [7:0] OFF_Y0       = 8'h10;
  localparam logic [7:0] OFF_Y1       = 8'h14;
  localparam logic [7:0] OFF_ACC_BASE = 8'h18;
  localparam logic [7:0] ACC_STRIDE   = 8'h08;
  localparam logic [7:0] OFF_MOVE_OUT = 8'h38;
  // Field positions and reset values
  localparam int CTRL_W = 9;
  localparam int CCR_W  = 8;
  localparam int OMR_SAT_BIT = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [CCR_W-1:0]  CCR_RST  = 8'h00;
  // Destination select codes
  localparam logic [2:0] DST_X0 = 3'h4;
  localparam logic [2:0] DST_Y0 = 3'h5;
  localparam logic [2:0] DST_Y1 = 3'h6;
  localparam logic [2:0] DST_Y  = 3'h7;
  // Negate corner values
  localparam logic [ACC_W-1:0] NEG_MOST  = 36'h8_0000_0000;
  localparam logic [ACC_W-1:0] NEG_LIMIT = 36'hf_8000_0000;
  localparam logic [WRD_W-1:0] MOVE_POS_LIM = 16'h7fff;
  localparam logic [WRD_W-1:0] MOVE_NEG_LIM = 16'h8000;

  typedef enum logic [1:0] {
    SSM_OP_NONE,
    SSM_OP_MULT,
    SSM_OP_NEG,
    SSM_OP_RSV
  } ssm_op_t;

  typedef struct packed {
    logic       move_en;
    logic [2:0] dest;
    logic [2:0] pair;
    ssm_op_t    op;
  } ssm_ctrl_t;

  typedef struct packed {
    logic sz;
    logic l;
    logic e;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } ssm_ccr_t;

  // Extension bits in use: bits 35..31 are not all equal
  function automatic logic ext_in_use(input logic [ACC_W-1:0] v);
    return !((&v[35:31]) || !(|v[35:31]));
  endfunction

  // Unnormalized: bits 31 and 30 are equal
  function automatic logic unnorm(input logic [ACC_W-1:0] v);
    return !(v[31] ^ v[30]);
  endfunction

  function automatic logic [7:0] acc_lo_addr(input int i);
    return OFF_ACC_BASE + 8'(i) * ACC_STRIDE;
  endfunction

  function automatic logic [7:0] acc_hi_addr(input int i);
    return acc_lo_addr(i) + 8'h04;
  endfunction
endpackage
`default_nettype wire

/* verilog/ssm_mult.sv */
// Purpose: Signed-by-unsigned 16x16 fractional multiplier
// Assumes: First source signed, second unsigned
// Notes:   Purely combinational; settles within one core cycle
`default_nettype none
`timescale 1ns/1ps
module ssm_mult
  import ssm_pkg::*;
(
  input  wire logic [WRD_W-1:0] src_s,
  input  wire logic [WRD_W-1:0] src_u,
  output logic      [ACC_W-1:0] prod,
  output logic                  ovf
);
  logic signed [33:0] s_ext;
  logic signed [33:0] u_ext;
  logic signed [33:0] raw;
  logic        [33:0] frac;

  // Sign extend one side, zero extend the other
  assign s_ext = {{18{src_s[15]}}, src_s};
  assign u_ext = {18'h0_0000, src_u};
  assign raw   = s_ext * u_ext;
  // Drop the redundant sign bit to align the fraction
  assign frac  = {raw[32:0], 1'b0}; // RULE16
  assign prod  = {{2{frac[33]}}, frac}; // RULE5
  // Product left the 32-bit fractional range
  assign ovf   = !((&frac[33:31]) || !(|frac[33:31])); // RULE7
endmodule // ssm_mult
`default_nettype wire

/* verilog/ssm_neg.sv */
// Purpose: 36-bit two's-complement negate with overflow handling
// Assumes: Operand already widened to 36 bits
// Notes:   Most negative value limits or stays put, per saturation
`default_nettype none
`timescale 1ns/1ps
module ssm_neg
  import ssm_pkg::*;
(
  input  wire logic [ACC_W-1:0] opnd,
  input  wire logic             sat_en,
  output logic      [ACC_W-1:0] res,
  output logic                  ovf,
  output logic                  borrow
);
  logic [ACC_W-1:0] diff;

  // Subtract from zero
  assign diff   = {ACC_W{1'b0}} - opnd; // RULE8
  assign ovf    = (opnd == NEG_MOST); // RULE11
  // Zero minus anything nonzero borrows out of the top
  assign borrow = |opnd; // RULE14
  assign res    = ovf ? (sat_en ? NEG_LIMIT : opnd) : diff; // RULE11
endmodule // ssm_neg
`default_nettype wire

/* verilog/ssm_core.sv */
// Purpose: Data ALU slice running multiply-signed-unsigned and negate
// Assumes: APB master, zero wait states, one instruction per CTRL write
// Notes:   Operand registers and accumulators are software visible
`default_nettype none
`timescale 1ns/1ps
// Overview of operation
// (RULE1) Multiply treats first source signed, second source unsigned.
// (RULE2) Sixteen by sixteen gives 32-bit product from eight source pairs.
// (RULE3) Sixteen-bit multiply destination receives product upper half.
// (RULE4) Multiply result is never limited, whatever saturation says.
// (RULE5) Accumulator destination gets product sign-extended over all bits.
// (RULE6) Multiply completes in one cycle, one instruction word.
// (RULE7) Multiply sets L, V, E, N, Z flags from the result.
// (RULE8) Negate computes zero minus destination, written back there.
// (RULE9) Word destinations widen with sign and low zeros; Y sign only.
// (RULE10) Negate may carry one parallel move finishing same cycle.
// (RULE11) Most negative negate limits when saturating, else unchanged.
// (RULE12) Negate sets L, E, SZ and U flags.
// (RULE13) Negate sets N when the 36-bit result is negative.
// (RULE14) Negate sets Z on zero, V on overflow, C on borrow.
// (RULE15) Negate takes one cycle, one word, for every move mode.
// (RULE16) Fractional product is raw product shifted left by one.
// (RULE17) Multiply keeps carry and performs no parallel move.
module ssm_core
  import ssm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  ssm_ctrl_t        ctrl_r;
  ssm_ctrl_t        ctrl_nxt;
  ssm_ccr_t         ccr_r;
  logic             sat_r;
  logic [WRD_W-1:0] x0_r;
  logic [WRD_W-1:0] y0_r;
  logic [WRD_W-1:0] y1_r;
  logic [ACC_W-1:0] acc_r [NUM_ACC];
  logic [WRD_W-1:0] move_out_r;
  logic [31:0]      prdata_r;
  logic             err_r;
  logic [31:0]      rd_val;
  logic             rd_hit;
  logic             wr_en;
  logic             exec;
  logic             do_mult;
  logic             do_neg;
  logic             do_move;
  logic [WRD_W-1:0] m_src_s;
  logic [WRD_W-1:0] m_src_u;
  logic [ACC_W-1:0] mprod;
  logic             movf;
  logic [ACC_W-1:0] nop;
  logic [ACC_W-1:0] nres;
  logic             novf;
  logic             nborrow;
  logic [ACC_W-1:0] wb;
  logic [ACC_W-1:0] mv_src;
  logic             mv_lim;
  logic [WRD_W-1:0] mv_val;

  // Zero-wait slave: every access finishes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = err_r;
  assign wr_en   = psel && penable && pwrite;
  assign ctrl_nxt = ssm_ctrl_t'(pwdata[CTRL_W-1:0]);
  // An instruction issues on the CTRL write's access edge
  assign exec    = wr_en && (paddr == OFF_CTRL) &&
                   (ctrl_nxt.op == SSM_OP_MULT || ctrl_nxt.op == SSM_OP_NEG);
  assign do_mult = exec && (ctrl_nxt.op == SSM_OP_MULT);
  assign do_neg  = exec && (ctrl_nxt.op == SSM_OP_NEG);
  // Moves ride only with negate; multiply ignores the move bit
  assign do_move = do_neg && ctrl_nxt.move_en; // RULE10 RULE17

  // Source pair select, signed operand first
  always_comb begin
    case (ctrl_nxt.pair) // RULE2
      3'h0:    begin m_src_s = x0_r; m_src_u = y1_r; end
      3'h1:    begin m_src_s = x0_r; m_src_u = y0_r; end
      3'h2:    begin m_src_s = y0_r; m_src_u = y1_r; end
      3'h3:    begin m_src_s = y0_r; m_src_u = y0_r; end
      3'h4:    begin m_src_s = y0_r; m_src_u = acc_r[0][31:16]; end
      3'h5:    begin m_src_s = y1_r; m_src_u = acc_r[1][31:16]; end
      3'h6:    begin m_src_s = y0_r; m_src_u = acc_r[2][31:16]; end
      default: begin m_src_s = y1_r; m_src_u = acc_r[2][31:16]; end
    endcase
  end

  ssm_mult u_mult (
    .src_s (m_src_s),
    .src_u (m_src_u),
    .prod  (mprod),
    .ovf   (movf)
  ); // RULE1

  // Widen the negate operand according to its destination
  always_comb begin
    case (ctrl_nxt.dest) // RULE9
      DST_X0:  nop = {{4{x0_r[15]}}, x0_r, 16'h0000};
      DST_Y0:  nop = {{4{y0_r[15]}}, y0_r, 16'h0000};
      DST_Y1:  nop = {{4{y1_r[15]}}, y1_r, 16'h0000};
      DST_Y:   nop = {{4{y1_r[15]}}, y1_r, y0_r};
      default: nop = acc_r[ctrl_nxt.dest[1:0]];
    endcase
  end

  ssm_neg u_neg (
    .opnd   (nop),
    .sat_en (sat_r),
    .res    (nres),
    .ovf    (novf),
    .borrow (nborrow)
  );

  // Multiply bypasses saturation entirely
  assign wb = do_mult ? mprod : nres; // RULE4

  // Parallel move stores an accumulator's middle word, limited if wide
  assign mv_src = acc_r[ctrl_nxt.pair[1:0]];
  assign mv_lim = ext_in_use(mv_src);
  assign mv_val = mv_lim ? (mv_src[35] ? MOVE_NEG_LIM : MOVE_POS_LIM)
                         : mv_src[31:16];

  // Control and mode registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= ssm_ctrl_t'(CTRL_RST);
      sat_r  <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_CTRL) begin
        ctrl_r <= ctrl_nxt;
      end
      if (wr_en && paddr == OFF_OMR) begin
        sat_r <= pwdata[OMR_SAT_BIT];
      end
    end
  end

  // Word registers; writeback lands on the issuing edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      x0_r <= 16'h0000;
      y0_r <= 16'h0000;
      y1_r <= 16'h0000;
    end else if (exec) begin
      case (ctrl_nxt.dest)
        DST_X0:  x0_r <= wb[31:16]; // RULE3
        DST_Y0:  y0_r <= wb[31:16]; // RULE3
        DST_Y1:  y1_r <= wb[31:16]; // RULE3
        DST_Y:   begin y1_r <= wb[31:16]; y0_r <= wb[15:0]; end
        default: ;
      endcase
    end else if (wr_en) begin
      if (paddr == OFF_X0) begin
        x0_r <= pwdata[15:0];
      end else if (paddr == OFF_Y0) begin
        y0_r <= pwdata[15:0];
      end else if (paddr == OFF_Y1) begin
        y1_r <= pwdata[15:0];
      end
    end
  end

  // Accumulators, full 36-bit writeback in one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_r[i] <= 36'h0_0000_0000;
      end
    end else begin
      for (int i = 0; i < NUM_ACC; i++) begin
        if (wr_en && paddr == acc_lo_addr(i)) begin
          acc_r[i][31:0] <= pwdata;
        end
        if (wr_en && paddr == acc_hi_addr(i)) begin
          acc_r[i][35:32] <= pwdata[3:0];
        end
      end
      if (exec && !ctrl_nxt.dest[2]) begin
        acc_r[ctrl_nxt.dest[1:0]] <= wb; // RULE5 RULE6 RULE15
      end
    end
  end

  // Parallel move result, same edge as the negate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      move_out_r <= 16'h0000;
    end else if (do_move) begin
      move_out_r <= mv_val; // RULE10
    end
  end

  // Condition codes; an issuing instruction overrides a software write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ccr_r <= ssm_ccr_t'(CCR_RST);
    end else if (do_mult) begin
      ccr_r.l <= ccr_r.l | movf; // RULE7
      ccr_r.v <= movf; // RULE7
      ccr_r.e <= ext_in_use(mprod); // RULE7
      ccr_r.u <= unnorm(mprod);
      ccr_r.n <= mprod[35]; // RULE7
      ccr_r.z <= (mprod == 36'h0_0000_0000); // RULE7
    end else if (do_neg) begin
      ccr_r.sz <= ccr_r.sz | (do_move && (mv_src[30] ^ mv_src[29])); // RULE12
      ccr_r.l  <= ccr_r.l | novf | (do_move && mv_lim); // RULE12
      ccr_r.e  <= ext_in_use(nres); // RULE12
      ccr_r.u  <= unnorm(nres); // RULE12
      ccr_r.n  <= nres[35]; // RULE13
      ccr_r.z  <= (nres == 36'h0_0000_0000); // RULE14
      ccr_r.v  <= novf; // RULE14
      ccr_r.c  <= nborrow; // RULE14
    end else if (wr_en && paddr == OFF_CCR) begin
      ccr_r <= ssm_ccr_t'(pwdata[CCR_W-1:0]);
    end
  end

  // Read decode; unmapped addresses read zero and flag an error
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == OFF_CTRL) begin
      rd_val = {23'h00_0000, ctrl_r};
    end else if (paddr == OFF_OMR) begin
      rd_val = {31'h0000_0000, sat_r};
    end else if (paddr == OFF_CCR) begin
      rd_val = {24'h00_0000, ccr_r};
    end else if (paddr == OFF_X0) begin
      rd_val = {16'h0000, x0_r};
    end else if (paddr == OFF_Y0) begin
      rd_val = {16'h0000, y0_r};
    end else if (paddr == OFF_Y1) begin
      rd_val = {16'h0000, y1_r};
    end else if (paddr == OFF_MOVE_OUT) begin
      rd_val = {16'h0000, move_out_r};
    end else begin
      rd_hit = 1'b0;
      for (int i = 0; i < NUM_ACC; i++) begin
        if (paddr == acc_lo_addr(i)) begin
          rd_val = acc_r[i][31:0];
          rd_hit = 1'b1;
        end
        if (paddr == acc_hi_addr(i)) begin
          rd_val = {28'h000_0000, acc_r[i][35:32]};
          rd_hit = 1'b1;
        end
      end
    end
  end

  // Capture read data in setup so the zero-wait access sees a flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      err_r    <= !rd_hit;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_mult_frac_value: assert property ( // RULE1
    do_mult |-> mprod[31:0] ==
      32'(($signed({{16{m_src_s[15]}}, m_src_s}) *
           $signed({16'h0000, m_src_u})) <<< 1))
    else $error("Fractional product value wrong");

  a_mult_word_upper: assert property ( // RULE3
    do_mult && ctrl_nxt.dest == DST_X0 |=> x0_r == $past(mprod[31:16]))
    else $error("Word destination missed product upper half");

  a_mult_acc_sext: assert property ( // RULE5
    do_mult && ctrl_nxt.dest == 3'h0 |=>
      acc_r[0] == {{4{$past(mprod[31])}}, $past(mprod[31:0])})
    else $error("Accumulator product not sign extended");

  a_mult_carry_kept: assert property ( // RULE17
    do_mult |=> ccr_r.c == $past(ccr_r.c) && $stable(move_out_r))
    else $error("Multiply touched carry or move");

  a_mult_zero_flag: assert property ( // RULE7
    do_mult |=> ccr_r.z == ($past(mprod) == 36'h0_0000_0000) &&
                ccr_r.n == $past(mprod[35]))
    else $error("Multiply Z or N flag wrong");

  a_neg_sat_limit: assert property ( // RULE11
    do_neg && ctrl_nxt.dest == 3'h1 && acc_r[1] == NEG_MOST && sat_r
      |=> acc_r[1] == NEG_LIMIT && ccr_r.v && ccr_r.l)
    else $error("Saturated negate did not limit");

  a_neg_nosat_keep: assert property ( // RULE11
    do_neg && ctrl_nxt.dest == 3'h1 && acc_r[1] == NEG_MOST && !sat_r
      |=> acc_r[1] == NEG_MOST)
    else $error("Unsaturated overflow changed operand");

  a_neg_acc_value: assert property ( // RULE8
    do_neg && ctrl_nxt.dest == 3'h0 && acc_r[0] != NEG_MOST
      |=> acc_r[0] == 36'(36'h0_0000_0000 - $past(acc_r[0])))
    else $error("Negate result wrong");

  a_neg_n_flag: assert property ( // RULE13
    do_neg |=> ccr_r.n == $past(nres[35]))
    else $error("Negate N flag wrong");

  a_neg_borrow_c: assert property ( // RULE14
    do_neg |=> ccr_r.c == ($past(nop) != 36'h0_0000_0000))
    else $error("Negate carry flag wrong");

  a_neg_word_widen: assert property ( // RULE9
    do_neg && ctrl_nxt.dest == DST_Y0 |-> nop[15:0] == 16'h0000 &&
      nop[35:32] == {4{y0_r[15]}})
    else $error("Word negate operand widened wrong");
endmodule // ssm_core
`default_nettype wire

/* test/ssm_host.sv */
// Purpose: APB master model standing in for the core decoder side
// Assumes: Caller is a single process; one transfer at a time
// Notes:   Inserts one idle cycle between transfers
`default_nettype none
`timescale 1ns/1ps
module ssm_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Wait for the answer; only the bench watchdog ends a stuck wait
    while (pready !== 1'b1) begin
      n++;
      @(posedge mclk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines stop showing the old values
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // ssm_host
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the multiply/negate unit
// Assumes: Zero wait state APB slave, instruction runs on CTRL write
// Notes:   Expected values are worked out by hand from the rules
`default_nettype none
`timescale 1ns/1ps
module tb;
  import ssm_pkg::*;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          miscompares = 0;
  int          cmp_count   = 0;

  // 250 MHz core clock
  always #2 mclk = ~mclk;

  ssm_host host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  ssm_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Register access helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] x,
                     input logic xe = 1'b0);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    cmp_count++;
    if (q !== x || e !== xe) begin
      miscompares++;
      $display("unexpected at %0t: addr %h got %h/%b want %h/%b",
               $time, a, q, e, x, xe);
    end
  endtask

  // Issue one instruction: op, source pair, destination, move flag
  task automatic exec(input logic [1:0] op, input logic [2:0] pr,
                      input logic [2:0] ds, input logic mv);
    wr(OFF_CTRL, {23'h0, mv, ds, pr, op});
  endtask

  task automatic t_mult_acc;
    wr(OFF_CCR, 32'h0);
    wr(OFF_X0, 32'h0000_fff4);
    wr(OFF_Y0, 32'h0000_0002);
    exec(2'h1, 3'h1, 3'h0, 1'b0);
    chk(8'h18, 32'hffff_ffd0);
    chk(8'h1c, 32'h0000_000f);
    chk(OFF_CCR, 32'h0000_0018);
  endtask

  task automatic t_mult_word;
    wr(OFF_OMR, 32'h1);
    wr(OFF_CCR, 32'h1);
    wr(OFF_X0, 32'h0000_4000);
    wr(OFF_Y1, 32'h0000_ffff);
    exec(2'h1, 3'h0, DST_X0, 1'b0);
    chk(OFF_X0, 32'h0000_7fff);
    chk(OFF_CCR, 32'h0000_0001);
  endtask

  task automatic t_mult_ovf;
    wr(OFF_CCR, 32'h0);
    wr(OFF_X0, 32'h0000_8000);
    exec(2'h1, 3'h0, 3'h1, 1'b0);
    chk(8'h20, 32'h0001_0000);
    chk(8'h24, 32'h0000_000f);
    chk(OFF_CCR, 32'h0000_007a);
    // Accumulator middle word as unsigned source
    wr(8'h28, 32'h0003_0000);
    exec(2'h1, 3'h7, 3'h3, 1'b0);
    chk(8'h30, 32'hffff_fffa);
  endtask

  task automatic t_neg_move;
    wr(OFF_OMR, 32'h0);
    wr(OFF_CCR, 32'h0);
    wr(8'h20, 32'h00aa_ff00);
    wr(8'h24, 32'h0);
    wr(8'h18, 32'h1234_5678);
    wr(8'h1c, 32'h0);
    exec(2'h2, 3'h0, 3'h1, 1'b1);
    chk(8'h20, 32'hff55_0100);
    chk(8'h24, 32'h0000_000f);
    chk(OFF_MOVE_OUT, 32'h0000_1234);
    chk(OFF_CCR, 32'h0000_0019);
  endtask

  // Most negative operand, saturation off then on
  task automatic t_neg_most;
    for (int s = 0; s < 2; s++) begin
      wr(OFF_OMR, 32'(s));
      wr(OFF_CCR, 32'h0);
      wr(8'h20, 32'h0);
      wr(8'h24, 32'h8);
      exec(2'h2, 3'h0, 3'h1, 1'b0);
      chk(8'h20, s ? 32'h8000_0000 : 32'h0);
      chk(8'h24, s ? 32'hf : 32'h8);
      chk(OFF_CCR, s ? 32'h4b : 32'h7b);
    end
  endtask

  task automatic t_neg_word;
    wr(OFF_Y1, 32'h1);
    exec(2'h2, 3'h0, DST_Y1, 1'b0);
    chk(OFF_Y1, 32'h0000_ffff);
    wr(OFF_Y1, 32'h0);
    wr(OFF_Y0, 32'h1);
    exec(2'h2, 3'h0, DST_Y, 1'b0);
    chk(OFF_Y0, 32'h0000_ffff);
    chk(OFF_Y1, 32'h0000_ffff);
    exec(2'h2, 3'h0, DST_Y0, 1'b0);
    chk(OFF_Y0, 32'h0000_0001);
    wr(OFF_CCR, 32'h0);
    wr(OFF_X0, 32'h0);
    exec(2'h2, 3'h0, DST_X0, 1'b0);
    chk(OFF_X0, 32'h0);
    chk(OFF_CCR, 32'h0000_0014);
  endtask

  // Verdict; the single exit of the run
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    chk(OFF_CTRL, 32'h0);
    chk(OFF_CCR, 32'h0);
    chk(8'h3c, 32'h0, 1'b1);
    t_mult_acc();
    t_mult_word();
    t_mult_ovf();
    t_neg_move();
    t_neg_most();
    t_neg_word();
    finish_test();
  end
endmodule // tb
`default_nettype wire
